// ---- sdrc_pkg.sv ----
// package: register map, field layout, reset values and timing constants
package sdrc_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] ISD_SETTINGS_OFS  = 12'h080;
  localparam logic [11:0] REV_SETTINGS_OFS  = 12'h082;
  localparam logic [31:0] ISD_SETTINGS_RST  = 32'h0000_0000;
  localparam logic [31:0] REV_SETTINGS_RST  = 32'h0000_0000;

  // ****************************************
  // field positions in initial_speed_detect_settings
  // ****************************************
  localparam int FLOAT_EN_BIT     = 28;
  localparam int REV_EN_BIT       = 27;
  localparam int HOLD_LSB         = 9;
  localparam int HOLD_W           = 4;
  localparam int STANDSTILL_LSB   = 6;
  localparam int STANDSTILL_W     = 3;
  localparam int ENTRY_SPEED_LSB  = 2;
  localparam int ENTRY_SPEED_W    = 4;
  localparam int CURRENT_CAP_LSB  = 0;
  localparam int CURRENT_CAP_W    = 2;

  // ****************************************
  // decoded value widths
  // ****************************************
  localparam int MV_W     = 11;  // millivolts
  localparam int PCT_W    = 10;  // tenths of a percent of max speed
  localparam int MA_W     = 13;  // milliamperes
  localparam int MS_W     = 14;  // milliseconds

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

endpackage : sdrc_pkg

// ---- sdrc_float_timer.sv ----
// module: timer that holds the outputs floating for a number of milliseconds
`timescale 1ns/100ps
module sdrc_float_timer
  import sdrc_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
) (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            ce,
  input  wire logic            start,
  input  wire logic            enable,
  input  wire logic [MS_W-1:0] duration_ms,
  output logic                 active
);

  localparam int PRE_W = $clog2(CYCLES_PER_MS + 1);

  logic [PRE_W-1:0] pre_cnt;
  logic [PRE_W-1:0] next_pre_cnt;
  logic [MS_W-1:0]  ms_left;
  logic [MS_W-1:0]  next_ms_left;
  logic             next_active;

  // ****************************************
  // next state: start reloads, each ms tick counts down
  // ****************************************
  always_comb begin
    next_pre_cnt = pre_cnt;
    next_ms_left = ms_left;
    next_active  = active;
    if (start) begin
      next_active  = enable;  // no float when disabled
      next_ms_left = duration_ms;
      next_pre_cnt = PRE_W'(CYCLES_PER_MS - 1);
    end else if (active) begin
      if (pre_cnt == '0) begin
        next_pre_cnt = PRE_W'(CYCLES_PER_MS - 1);
        if (ms_left <= MS_W'(1)) begin
          next_active  = 1'b0;  // hold time elapsed
          next_ms_left = '0;
        end else begin
          next_ms_left = ms_left - MS_W'(1);
        end
      end else begin
        next_pre_cnt = pre_cnt - PRE_W'(1);
      end
    end
  end

  // registers, frozen while ce is low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_cnt <= '0;
      ms_left <= '0;
      active  <= 1'b0;
    end else if (ce) begin
      pre_cnt <= next_pre_cnt;
      ms_left <= next_ms_left;
      active  <= next_active;
    end
  end

endmodule : sdrc_float_timer

// ---- sdrc_top.sv ----
// module: initial speed detect and reverse drive settings registers with decode
`timescale 1ns/100ps
module sdrc_top
  import sdrc_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr_en,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_rd_en,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rd_valid,
  input  wire logic              isd_start,
  input  wire logic [MV_W-1:0]   bemf_mv,
  input  wire logic              rev_decel_active,
  input  wire logic [PCT_W-1:0]  speed_pct_x10,
  output logic                   outputs_float,
  output logic                   motor_standstill,
  output logic                   reversal_openloop_req,
  output logic      [MV_W-1:0]   standstill_bemf_level,
  output logic      [PCT_W-1:0]  reversal_openloop_entry_speed,
  output logic      [MA_W-1:0]   reversal_current_cap,
  output logic      [MS_W-1:0]   float_hold_duration
);

  // ****************************************
  // decode functions
  // ****************************************
  function automatic logic [MV_W-1:0] level_mv(input logic [STANDSTILL_W-1:0] code);
    case (code)
      3'h0:    level_mv = 11'h032;  // 50 mV
      3'h1:    level_mv = 11'h04b;
      3'h2:    level_mv = 11'h064;
      3'h3:    level_mv = 11'h0fa;
      3'h4:    level_mv = 11'h1f4;
      3'h5:    level_mv = 11'h2ee;
      3'h6:    level_mv = 11'h3e8;
      default: level_mv = 11'h5dc;  // 1500 mV
    endcase
  endfunction : level_mv

  function automatic logic [PCT_W-1:0] entry_x10(input logic [ENTRY_SPEED_W-1:0] code);
    case (code)
      4'h0:    entry_x10 = 10'h019;  // 2.5 percent
      4'h1:    entry_x10 = 10'h032;
      4'h2:    entry_x10 = 10'h04b;
      4'h3:    entry_x10 = 10'h064;
      4'h4:    entry_x10 = 10'h07d;
      4'h5:    entry_x10 = 10'h096;
      4'h6:    entry_x10 = 10'h0c8;
      4'h7:    entry_x10 = 10'h0fa;
      4'h8:    entry_x10 = 10'h12c;
      4'h9:    entry_x10 = 10'h190;
      4'ha:    entry_x10 = 10'h1f4;
      4'hb:    entry_x10 = 10'h258;
      4'hc:    entry_x10 = 10'h2bc;
      4'hd:    entry_x10 = 10'h320;
      4'he:    entry_x10 = 10'h384;
      default: entry_x10 = 10'h3e8;  // 100 percent
    endcase
  endfunction : entry_x10

  function automatic logic [MA_W-1:0] cap_ma(input logic [CURRENT_CAP_W-1:0] code);
    case (code)
      2'h0:    cap_ma = 13'h05dc;  // 1.5 A
      2'h1:    cap_ma = 13'h09c4;
      2'h2:    cap_ma = 13'h0dac;
      default: cap_ma = 13'h1388;  // 5.0 A
    endcase
  endfunction : cap_ma

  function automatic logic [MS_W-1:0] hold_ms(input logic [HOLD_W-1:0] code);
    case (code)
      4'h0:    hold_ms = 14'h000a;  // 10 ms
      4'h1:    hold_ms = 14'h0032;
      4'h2:    hold_ms = 14'h0064;
      4'h3:    hold_ms = 14'h00c8;
      4'h4:    hold_ms = 14'h012c;
      4'h5:    hold_ms = 14'h0190;
      4'h6:    hold_ms = 14'h01f4;
      4'h7:    hold_ms = 14'h02ee;
      4'h8:    hold_ms = 14'h03e8;
      4'h9:    hold_ms = 14'h07d0;
      4'ha:    hold_ms = 14'h0bb8;
      4'hb:    hold_ms = 14'h0fa0;
      4'hc:    hold_ms = 14'h1388;
      4'hd:    hold_ms = 14'h1d4c;
      4'he:    hold_ms = 14'h2710;
      default: hold_ms = 14'h3a98;  // 15 s
    endcase
  endfunction : hold_ms

  // ****************************************
  // register file
  // ****************************************
  logic [31:0] isd_settings;
  logic [31:0] reverse_drive_settings;
  logic [31:0] next_isd_settings;
  logic [31:0] next_reverse_drive_settings;
  logic [31:0] next_reg_rdata;
  logic        next_reg_rd_valid;

  logic                     rev_en;
  logic                     float_en;
  logic [STANDSTILL_W-1:0]  standstill_code;
  logic [ENTRY_SPEED_W-1:0] entry_code;
  logic [CURRENT_CAP_W-1:0] cap_code;
  logic [HOLD_W-1:0]        hold_code;

  assign rev_en          = isd_settings[REV_EN_BIT];
  assign float_en        = isd_settings[FLOAT_EN_BIT];
  assign standstill_code = isd_settings[STANDSTILL_LSB +: STANDSTILL_W];
  assign entry_code      = isd_settings[ENTRY_SPEED_LSB +: ENTRY_SPEED_W];
  assign cap_code        = isd_settings[CURRENT_CAP_LSB +: CURRENT_CAP_W];
  assign hold_code       = isd_settings[HOLD_LSB +: HOLD_W];

  // write decode and read mux; unmapped reads return zero
  always_comb begin
    next_isd_settings           = isd_settings;
    next_reverse_drive_settings = reverse_drive_settings;
    next_reg_rdata              = reg_rdata;
    next_reg_rd_valid           = reg_rd_en;
    if (reg_wr_en) begin
      if (reg_addr == ISD_SETTINGS_OFS) begin
        next_isd_settings = reg_wdata;
      end
      if (reg_addr == REV_SETTINGS_OFS) begin
        next_reverse_drive_settings = reg_wdata;
      end
    end
    if (reg_rd_en) begin
      case (reg_addr)
        ISD_SETTINGS_OFS: next_reg_rdata = isd_settings;
        REV_SETTINGS_OFS: next_reg_rdata = reverse_drive_settings;
        default:          next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      isd_settings           <= ISD_SETTINGS_RST;
      reverse_drive_settings <= REV_SETTINGS_RST;
      reg_rdata              <= 32'h0000_0000;
      reg_rd_valid           <= 1'b0;
    end else if (ce) begin
      isd_settings           <= next_isd_settings;
      reverse_drive_settings <= next_reverse_drive_settings;
      reg_rdata              <= next_reg_rdata;
      reg_rd_valid           <= next_reg_rd_valid;
    end
  end

  // ****************************************
  // decoded settings and decisions
  // ****************************************
  logic [MV_W-1:0]  next_standstill_bemf_level;
  logic [PCT_W-1:0] next_entry_speed;
  logic [MA_W-1:0]  next_current_cap;
  logic [MS_W-1:0]  next_float_hold_duration;
  logic             next_motor_standstill;
  logic             next_openloop_req;

  // translate codes and apply reversal gating
  always_comb begin
    next_standstill_bemf_level = level_mv(standstill_code);
    next_float_hold_duration   = hold_ms(hold_code);
    next_entry_speed           = '0;
    next_current_cap           = '0;
    if (rev_en) begin
      next_entry_speed = entry_x10(entry_code);
      next_current_cap = cap_ma(cap_code);
    end
    // standstill when back-EMF is below the selected level
    next_motor_standstill = (bemf_mv < next_standstill_bemf_level);
    // open loop once reverse deceleration falls to the entry speed
    next_openloop_req = rev_en && rev_decel_active
                        && (speed_pct_x10 <= entry_x10(entry_code));
  end

  // decoded outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      standstill_bemf_level         <= '0;
      reversal_openloop_entry_speed <= '0;
      reversal_current_cap          <= '0;
      float_hold_duration           <= '0;
      motor_standstill              <= 1'b0;
      reversal_openloop_req         <= 1'b0;
    end else if (ce) begin
      standstill_bemf_level         <= next_standstill_bemf_level;
      reversal_openloop_entry_speed <= next_entry_speed;
      reversal_current_cap          <= next_current_cap;
      float_hold_duration           <= next_float_hold_duration;
      motor_standstill              <= next_motor_standstill;
      reversal_openloop_req         <= next_openloop_req;
    end
  end

  // ****************************************
  // float hold timer
  // ****************************************
  // started by speed detection, floats outputs only when enabled
  sdrc_float_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) i_sdrc_float_timer (
    .clk         (clk),
    .rst_b       (rst_b),
    .ce          (ce),
    .start       (isd_start),
    .enable      (float_en),
    .duration_ms (hold_ms(hold_code)),
    .active      (outputs_float)
  );

endmodule : sdrc_top

// ---- sdrc_tb_pkg.sv ----
// package: decode tables shared by the checker and the bench
package sdrc_tb_pkg;
  localparam int LVL_MV[8]   = '{50, 75, 100, 250, 500, 750, 1000, 1500};
  localparam int ENT_X10[16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500, 600, 700, 800, 900, 1000};
  localparam int CAP_MA[4]   = '{1500, 2500, 3500, 5000};
  localparam int HOLD_MS[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000, 4000, 5000, 7500, 10000,
                                 15000};
endpackage : sdrc_tb_pkg

// ---- sdrc_top_sva.sv ----
// checker: port assertions for the settings registers
`timescale 1ns/100ps
module sdrc_top_sva
  import sdrc_pkg::*;
  import sdrc_tb_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr_en,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_rd_en,
  input wire logic [31:0]       reg_rdata,
  input wire logic              reg_rd_valid,
  input wire logic              isd_start,
  input wire logic              outputs_float,
  input wire logic [MV_W-1:0]   standstill_bemf_level,
  input wire logic [PCT_W-1:0]  reversal_openloop_entry_speed,
  input wire logic [MA_W-1:0]   reversal_current_cap,
  input wire logic [MS_W-1:0]   float_hold_duration
);
  logic [31:0] isd_q, rev_q, prev_q, rd_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow copies of both registers and of the expected read word
  always_ff @(posedge clk) begin
    prev_q <= isd_q;
    if (!rst_b) begin
      isd_q <= ISD_SETTINGS_RST;
      rev_q <= REV_SETTINGS_RST;
      rd_q  <= '0;
    end else if (ce) begin
      if (reg_wr_en && reg_addr == ISD_SETTINGS_OFS) isd_q <= reg_wdata;
      if (reg_wr_en && reg_addr == REV_SETTINGS_OFS) rev_q <= reg_wdata;
      if (reg_rd_en) rd_q <= (reg_addr == ISD_SETTINGS_OFS) ? isd_q : (reg_addr == REV_SETTINGS_OFS) ? rev_q : '0;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  rd_valid_a:
    assert property (ce && reg_rd_en |=> reg_rd_valid) else $error("read not answered");
  rd_only_a:
    assert property (reg_rd_valid && $past(ce) |-> $past(reg_rd_en)) else $error("answer without read");
  rd_data_a:
    assert property (reg_rd_valid |-> reg_rdata == rd_q) else $error("read word wrong");
  level_map_a:
    assert property ($past(rst_b) && $past(ce) |-> standstill_bemf_level == LVL_MV[prev_q[8:6]])
      else $error("standstill level wrong");
  entry_map_a:
    assert property ($past(rst_b) && $past(ce) |->
      reversal_openloop_entry_speed == (prev_q[REV_EN_BIT] ? ENT_X10[prev_q[5:2]] : 0)) else $error("entry wrong");
  cap_map_a:
    assert property ($past(rst_b) && $past(ce) |->
      reversal_current_cap == (prev_q[REV_EN_BIT] ? CAP_MA[prev_q[1:0]] : 0)) else $error("cap wrong");
  hold_map_a:
    assert property ($past(rst_b) && $past(ce) |-> float_hold_duration == HOLD_MS[prev_q[12:9]])
      else $error("hold wrong");
  float_start_a:
    assert property (ce && isd_start && isd_q[FLOAT_EN_BIT] |=> outputs_float [*8]) else $error("float not held");
  float_off_a:
    assert property (!isd_q[FLOAT_EN_BIT] && !outputs_float |=> !outputs_float) else $error("float while off");
endmodule : sdrc_top_sva

bind sdrc_top sdrc_top_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_sdrc_top_sva (.clk(clk), .rst_b(rst_b), .ce(ce),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .isd_start(isd_start), .outputs_float(outputs_float),
  .standstill_bemf_level(standstill_bemf_level), .reversal_openloop_entry_speed(reversal_openloop_entry_speed),
  .reversal_current_cap(reversal_current_cap), .float_hold_duration(float_hold_duration));

// ---- sdrc_top_bench.sv ----
// bench: directed scenarios for the settings registers
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0d got %0d", n, e, s); end end
module sdrc_top_bench
  import sdrc_pkg::*;
  import sdrc_tb_pkg::*;
;
  localparam int CPM = 4;
  logic              clk = 0, rst_b = 0, ce = 1, reg_wr_en = 0, reg_rd_en = 0, isd_start = 0, rev_decel_active = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0]       reg_wdata = '0, reg_rdata;
  logic [MV_W-1:0]   bemf_mv = '0, standstill_bemf_level;
  logic [PCT_W-1:0]  speed_pct_x10 = '0, reversal_openloop_entry_speed;
  logic [MA_W-1:0]   reversal_current_cap;
  logic [MS_W-1:0]   float_hold_duration;
  logic              reg_rd_valid, outputs_float, motor_standstill, reversal_openloop_req;
  int                failures = 0, checks = 0;
  sdrc_top #(.CYCLES_PER_MS(CPM)) i_sdrc_top (
    .clk                           (clk),
    .rst_b                         (rst_b),
    .ce                            (ce),
    .reg_addr                      (reg_addr),
    .reg_wr_en                     (reg_wr_en),
    .reg_wdata                     (reg_wdata),
    .reg_rd_en                     (reg_rd_en),
    .reg_rdata                     (reg_rdata),
    .reg_rd_valid                  (reg_rd_valid),
    .isd_start                     (isd_start),
    .bemf_mv                       (bemf_mv),
    .rev_decel_active              (rev_decel_active),
    .speed_pct_x10                 (speed_pct_x10),
    .outputs_float                 (outputs_float),
    .motor_standstill              (motor_standstill),
    .reversal_openloop_req         (reversal_openloop_req),
    .standstill_bemf_level         (standstill_bemf_level),
    .reversal_openloop_entry_speed (reversal_openloop_entry_speed),
    .reversal_current_cap          (reversal_current_cap),
    .float_hold_duration           (float_hold_duration)
  );
  always #25 clk = ~clk;
  // ****************************************
  // bus and timing helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1;
    step(1);
    reg_wr_en = 0;
    step(1);  // idle edge so a following call never re-raises a strobe at once
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    reg_addr = a;
    reg_rd_en = 1;
    step(1);
    reg_rd_en = 0;
    `CHK("rd_valid", 1'b1, reg_rd_valid)
    `CHK("rdata", e, reg_rdata)
    step(1);  // idle edge between transfers
  endtask : rd
  task automatic conclude;
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_vals;
    rd(REV_SETTINGS_OFS, 32'h0);
    rd(ISD_SETTINGS_OFS, 32'h0);
    `CHK("level", 50, standstill_bemf_level)
    `CHK("entry", 0, reversal_openloop_entry_speed)
    `CHK("hold", 10, float_hold_duration)
  endtask : t_reset_vals
  task automatic t_codes;
    logic [31:0] d;
    for (int c = 0; c < 16; c++) begin
      d = {4'h0, 1'b1, 14'h0, c[3:0], c[2:0], c[3:0], c[1:0]};
      wr(ISD_SETTINGS_OFS, d);
      step(1);
      `CHK("level", LVL_MV[c%8], standstill_bemf_level)
      `CHK("entry", ENT_X10[c], reversal_openloop_entry_speed)
      `CHK("cap", CAP_MA[c%4], reversal_current_cap)
      `CHK("hold", HOLD_MS[c], float_hold_duration)
      rd(ISD_SETTINGS_OFS, d);
    end
  endtask : t_codes
  task automatic t_gate;
    wr(ISD_SETTINGS_OFS, 32'h0000_003f);  // top entry and cap codes, reversal off
    rev_decel_active = 1;
    step(2);
    `CHK("cap_off", 0, reversal_current_cap)
    `CHK("req_off", 1'b0, reversal_openloop_req)
    wr(ISD_SETTINGS_OFS, 32'h0800_0010);  // reversal on, entry 12.5 percent
    speed_pct_x10 = 10'd125;
    step(2);
    `CHK("req_at", 1'b1, reversal_openloop_req)
    speed_pct_x10 = 10'd126;
    step(2);
    `CHK("req_above", 1'b0, reversal_openloop_req)
  endtask : t_gate
  task automatic t_still;
    bemf_mv = 11'd49;
    step(2);
    `CHK("still_49", 1'b1, motor_standstill)
    bemf_mv = 11'd50;
    step(2);
    `CHK("still_50", 1'b0, motor_standstill)
  endtask : t_still
  task automatic t_regs;
    wr(REV_SETTINGS_OFS, 32'h5a3c_f069);
    wr(12'h084, 32'hffff_ffff);  // unmapped write is dropped
    rd(12'h084, 32'h0);
    reg_addr = REV_SETTINGS_OFS;  // write and read together: read sees old word
    reg_wdata = 32'h0000_0001;
    reg_wr_en = 1;
    reg_rd_en = 1;
    step(1);
    reg_wr_en = 0;
    reg_rd_en = 0;
    `CHK("rd_valid", 1'b1, reg_rd_valid)
    `CHK("rdata", 32'h5a3c_f069, reg_rdata)
    step(1);
    ce = 0;
    wr(REV_SETTINGS_OFS, 32'h0000_0077);  // frozen, must be ignored
    ce = 1;
    rd(REV_SETTINGS_OFS, 32'h0000_0001);
  endtask : t_regs
  task automatic t_float;
    int n;
    wr(ISD_SETTINGS_OFS, 32'h1000_0000);  // float on, shortest hold
    isd_start = 1;
    step(1);
    isd_start = 0;
    n = 0;
    while (outputs_float === 1'b1 && n < 100) begin
      n++;
      step(1);
    end
    if (n >= 100) begin
      failures++;
      return;  // timed out: main sequence goes on to the verdict
    end
    `CHK("float_cycles", HOLD_MS[0] * CPM, n)
    wr(ISD_SETTINGS_OFS, 32'h0000_0000);
    isd_start = 1;
    step(1);
    isd_start = 0;
    step(1);
    `CHK("float_off", 1'b0, outputs_float)
  endtask : t_float
  // main sequence
  initial begin
    step(6);
    rst_b = 1;
    step(2);
    t_reset_vals();
    t_codes();
    t_gate();
    t_still();
    t_regs();
    t_float();
    conclude();
  end
endmodule : sdrc_top_bench
